//--- hms_consts.svh
// Supervisor timing, address and width constants
`ifndef HMS_CONSTS_SVH
`define HMS_CONSTS_SVH

`define HMS_CLK_HZ       20000000
`define HMS_HOLD_MS      1
`define HMS_RELEASE_MS   200
`define HMS_SELF_RST_MS  50
`define HMS_HOLD_CYC     (`HMS_HOLD_MS * (`HMS_CLK_HZ / 1000))
`define HMS_RELEASE_CYC  (`HMS_RELEASE_MS * (`HMS_CLK_HZ / 1000))
`define HMS_I2C_HZ       100000
`define HMS_I2C_QTR      (`HMS_CLK_HZ / (4 * `HMS_I2C_HZ))
`define HMS_CNT_W        22
`define HMS_DIV_W        6
`define HMS_ACK_BIT      4'h8
`define HMS_IDX_ADDR     2'h1
`define HMS_IDX_WDATA    2'h2
`define HMS_IDX_RX       2'h3
`define HMS_EE_DEV       7'h51
`define HMS_EE_WR        {`HMS_EE_DEV, 1'b0}
`define HMS_EE_RD        {`HMS_EE_DEV, 1'b1}
`define HMS_SLV_ADDR     7'h3c

`endif

//--- hms_pkg.sv
// Supervisor and I2C master types
package hms_pkg;
`include "hms_consts.svh"

  typedef enum logic [1:0] {
    HMS_ST_HOLD = 2'b00,
    HMS_ST_WAIT = 2'b01,
    HMS_ST_RUN  = 2'b10,
    HMS_ST_HRST = 2'b11
  } hms_sup_st_t;

  typedef enum logic [1:0] {
    HMS_I2C_IDLE  = 2'b00,
    HMS_I2C_START = 2'b01,
    HMS_I2C_BIT   = 2'b10,
    HMS_I2C_STOP  = 2'b11
  } hms_i2c_st_t;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hms_ee_cmd_t;

  typedef struct packed {
    logic       done;
    logic       nack;
    logic [7:0] rdata;
  } hms_ee_rsp_t;

  typedef struct packed {
    hms_i2c_st_t          st;
    logic [`HMS_DIV_W-1:0] div;
    logic [1:0]           ph;
    logic [3:0]           bitn;
    logic [1:0]           idx;
    logic [7:0]           sh;
    hms_ee_cmd_t          cmd;
    hms_ee_rsp_t          rsp;
    logic                 scl_oe;
    logic                 sda_oe;
  } hms_i2c_t;

  typedef struct packed {
    hms_sup_st_t          st;
    logic [`HMS_CNT_W-1:0] cnt;
    logic                 pull;
    logic                 pend;
    logic                 tmo;
    logic                 self_rst;
    logic                 pwr_q;
    logic                 pwr_lost;
    logic                 bypass;
    logic                 refused;
  } hms_sup_t;

endpackage : hms_pkg

//--- hms_i2c_master.sv
// Single-byte EEPROM I2C master
`timescale 1ns/1ps
`include "hms_consts.svh"

module hms_i2c_master (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 start,
  input  wire hms_pkg::hms_ee_cmd_t cmd,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      busy,
  output hms_pkg::hms_ee_rsp_t      rsp,
  output logic                      scl_oe,
  output logic                      sda_oe
);
  import hms_pkg::*;

  hms_i2c_t st_r;
  hms_i2c_t st_nxt;
  logic     tick;
  logic     rx;
  logic     last;

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rsp.done = 1'b0;
    rx              = st_r.cmd.rd && (st_r.idx == `HMS_IDX_RX);
    // Slave may stretch the clock: high phase waits for scl
    tick = (st_r.div == `HMS_DIV_W'(`HMS_I2C_QTR - 1)) && (st_r.ph != 2'h1 || scl_i);
    last = st_r.rsp.nack || (!st_r.cmd.rd && st_r.idx == `HMS_IDX_WDATA) || rx;
    if (st_r.st != HMS_I2C_IDLE) begin
      if (tick) begin
        st_nxt.div = '0;
        st_nxt.ph  = st_r.ph + 2'h1;
      end else if (st_r.div != `HMS_DIV_W'(`HMS_I2C_QTR - 1)) begin
        st_nxt.div = st_r.div + `HMS_DIV_W'(1);
      end
    end
    unique case (st_r.st)
      HMS_I2C_IDLE: begin
        if (start) begin
          // [R15] device write address first
          st_nxt.sh       = `HMS_EE_WR;
          st_nxt.st       = HMS_I2C_START;
          st_nxt.cmd      = cmd;
          st_nxt.idx      = '0;
          st_nxt.bitn     = '0;
          st_nxt.ph       = '0;
          st_nxt.div      = '0;
          st_nxt.rsp.nack = 1'b0;
          st_nxt.sda_oe   = 1'b0;
        end
      end
      HMS_I2C_START: begin
        if (tick) begin
          unique case (st_r.ph)
            2'h0: st_nxt.scl_oe = 1'b0;
            2'h1: st_nxt.sda_oe = 1'b1;
            2'h2: st_nxt.scl_oe = 1'b1;
            2'h3: begin
              st_nxt.st     = HMS_I2C_BIT;
              st_nxt.sda_oe = ~st_r.sh[7];
            end
          endcase
        end
      end
      HMS_I2C_BIT: begin
        if (tick) begin
          unique case (st_r.ph)
            2'h0: st_nxt.scl_oe = 1'b0;
            2'h1: begin
              if (st_r.bitn == `HMS_ACK_BIT) begin
                st_nxt.rsp.nack = st_r.rsp.nack | (~rx & sda_i);
              end else if (rx) begin
                st_nxt.rsp.rdata = {st_r.rsp.rdata[6:0], sda_i};
              end
            end
            2'h2: st_nxt.scl_oe = 1'b1;
            2'h3: begin
              if (st_r.bitn != `HMS_ACK_BIT) begin
                st_nxt.bitn   = st_r.bitn + 4'h1;
                st_nxt.sh     = {st_r.sh[6:0], 1'b0};
                // Ack slot released; on read it is the closing NACK
                st_nxt.sda_oe = (st_r.bitn == `HMS_ACK_BIT - 4'h1 || rx) ? 1'b0 : ~st_r.sh[6];
              end else begin
                st_nxt.bitn = '0;
                if (last) begin
                  st_nxt.st     = HMS_I2C_STOP;
                  st_nxt.sda_oe = 1'b1;
                end else if (st_r.cmd.rd && st_r.idx == `HMS_IDX_ADDR) begin
                  // [R15] repeated start with read address
                  st_nxt.st     = HMS_I2C_START;
                  st_nxt.sh     = `HMS_EE_RD;
                  st_nxt.idx    = `HMS_IDX_WDATA;
                  st_nxt.sda_oe = 1'b0;
                end else begin
                  // [R16] one 8-bit word address byte
                  st_nxt.sh     = (st_r.idx == '0) ? st_r.cmd.addr : st_r.cmd.wdata;
                  st_nxt.idx    = st_r.idx + 2'h1;
                  st_nxt.sda_oe = (st_r.idx == `HMS_IDX_WDATA) ? 1'b0 :
                                  ((st_r.idx == '0) ? ~st_r.cmd.addr[7] : ~st_r.cmd.wdata[7]);
                end
              end
            end
          endcase
        end
      end
      HMS_I2C_STOP: begin
        if (tick) begin
          unique case (st_r.ph)
            2'h0: st_nxt.scl_oe = 1'b0;
            2'h1: st_nxt.scl_oe = 1'b0;
            2'h2: st_nxt.sda_oe = 1'b0;
            2'h3: begin
              // [R20] busy ends only after stop, bus idle
              st_nxt.st       = HMS_I2C_IDLE;
              st_nxt.rsp.done = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{st: HMS_I2C_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy   = (st_r.st != HMS_I2C_IDLE);
  assign rsp    = st_r.rsp;
  assign scl_oe = st_r.scl_oe;
  assign sda_oe = st_r.sda_oe;

endmodule : hms_i2c_master

//--- hms_supervisor.sv
// Host module supervisor: reset hold, monitoring, link routing, EEPROM access
`timescale 1ns/1ps
`include "hms_consts.svh"

// Operation
// [R1] Host stays in reset while the hold line is pulled low.
// [R2] Hold line is pulled from reset, inside the host self-reset interval.
// [R3] Hold line is only pulled low or released, never driven high.
// [R4] Pull the line low for at least 1 ms, then release it.
// [R5] After release, wait up to 200 ms for the line to read high.
// [R6] A low line not caused by us is a host self-reset.
// [R7] Both host rail inputs high means powered; either low means down.
// [R8] In passthrough the host UART pins reach the transceiver directly.
// [R9] Otherwise host UART meets the host-side UART, transceiver the network one.
// [R10] Otherwise host transmit enable is monitored; drive enable is separate.
// [R11] Host is SPI master; we answer only while select is low.
// [R12] In passthrough the host SPI signals are ignored.
// [R13] With host out of reset we are only an I2C slave.
// [R14] EEPROM access only while holding host, before releasing it.
// [R15] EEPROM at 7-bit address 0x51, bytes 0xa2 write, 0xa3 read.
// [R16] EEPROM byte address is 8 bits, 256 bytes.
// [R17] Our slave address differs from host devices and the EEPROM.
// [R18] No I2C use at all when no host is attached.
// [R19] Passthrough is the default; we leave it by driving its select high.
// [R20] Back to slave only after the final stop, bus idle.
module hms_supervisor #(
  parameter int HOLD_CYC    = `HMS_HOLD_CYC,
  parameter int RELEASE_CYC = `HMS_RELEASE_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // Host reset line, open drain
  input  wire logic                 host_hold_line_n_i,
  output logic                      host_hold_line_n_o,
  output logic                      host_hold_line_n_oe,
  input  wire logic                 hold_req,
  input  wire logic                 release_req,
  input  wire logic                 auto_release,
  output logic                      host_held,
  output logic                      host_running,
  output logic                      host_self_reset,
  output logic                      release_timeout,
  // Host rails
  input  wire logic                 dock_rail_status,
  input  wire logic                 wire_conn_rail_status,
  output logic                      host_power_down,
  output logic                      host_power_lost,
  // Passthrough select, driven high or left floating
  input  wire logic                 passthrough_req,
  output logic                      passthrough_select_n_o,
  output logic                      passthrough_select_n_oe,
  output logic                      passthrough_active,
  // UART routing
  input  wire logic                 host_txd,
  output logic                      host_rxd,
  input  wire logic                 half_duplex_tx_enable_n,
  output logic                      host_tx_enable_monitor,
  output logic                      host_uart_rxd,
  input  wire logic                 host_uart_txd,
  input  wire logic                 net_uart_txd,
  output logic                      net_uart_rxd,
  input  wire logic                 net_uart_de,
  output logic                      xcvr_txd,
  input  wire logic                 xcvr_rxd,
  output logic                      transceiver_drive_enable,
  // Host SPI link
  input  wire logic                 host_link_select_n,
  input  wire logic                 spi_core_miso,
  output logic                      spi_core_select_n,
  output logic                      host_miso_o,
  output logic                      host_miso_oe,
  input  wire logic                 attn_req,
  output logic                      host_attention_irq_n_o,
  output logic                      host_attention_irq_n_oe,
  // Shared I2C bus
  input  wire logic                 i2c_scl_i,
  input  wire logic                 i2c_sda_i,
  output logic                      i2c_scl_o,
  output logic                      i2c_scl_oe,
  output logic                      i2c_sda_o,
  output logic                      i2c_sda_oe,
  output logic                      i2c_slave_en,
  output logic [6:0]                i2c_slave_addr,
  // EEPROM requests
  input  wire logic                 ee_req,
  input  wire hms_pkg::hms_ee_cmd_t ee_cmd,
  output logic                      ee_busy,
  output hms_pkg::hms_ee_rsp_t      ee_rsp,
  output logic                      ee_refused
);
  import hms_pkg::*;

  hms_sup_t st_r;
  hms_sup_t st_nxt;
  logic     host_present;
  logic     ee_go;
  logic     min_done;
  logic     m_scl_oe;
  logic     m_sda_oe;

  // ----------------------------------------
  // Host presence
  // ----------------------------------------
  // [R7] both rails must read high
  assign host_present = dock_rail_status & wire_conn_rail_status;

  // ----------------------------------------
  // Reset hold sequencer
  // ----------------------------------------
  assign min_done = (st_r.cnt == `HMS_CNT_W'(HOLD_CYC - 1));

  always_comb begin
    st_nxt          = st_r;
    st_nxt.self_rst = 1'b0;
    st_nxt.refused  = 1'b0;
    st_nxt.pwr_q    = host_present;
    st_nxt.pwr_lost = st_r.pwr_q & ~host_present;
    st_nxt.bypass   = passthrough_req;
    ee_go           = 1'b0;
    if (release_req) begin
      st_nxt.pend = 1'b1;
    end
    unique case (st_r.st)
      HMS_ST_HOLD: begin
        // [R4] minimum pull time before release
        if (!min_done) begin
          st_nxt.cnt = st_r.cnt + `HMS_CNT_W'(1);
        end
        // [R14] master access only while host is held
        // [R18] refused without an attached host
        if (ee_req) begin
          if (host_present && !ee_busy) begin
            ee_go = 1'b1;
          end else begin
            st_nxt.refused = 1'b1;
          end
        end
        // [R20] release waits for the master
        if (min_done && (st_r.pend || release_req || auto_release) && !ee_busy && !ee_req) begin
          st_nxt.st   = HMS_ST_WAIT;
          st_nxt.pull = 1'b0;
          st_nxt.cnt  = '0;
          st_nxt.pend = 1'b0;
        end
      end
      HMS_ST_WAIT: begin
        // [R5] sample until high, flag after 200 ms
        if (host_hold_line_n_i) begin
          st_nxt.st = HMS_ST_RUN;
        end else if (st_r.cnt == `HMS_CNT_W'(RELEASE_CYC - 1)) begin
          st_nxt.tmo = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + `HMS_CNT_W'(1);
        end
      end
      HMS_ST_RUN: begin
        // [R6] low line we did not cause
        if (!host_hold_line_n_i) begin
          st_nxt.st       = HMS_ST_HRST;
          st_nxt.self_rst = 1'b1;
        end
      end
      HMS_ST_HRST: begin
        if (host_hold_line_n_i) begin
          st_nxt.st = HMS_ST_RUN;
        end
      end
    endcase
    if (ee_req && st_r.st != HMS_ST_HOLD) begin
      st_nxt.refused = 1'b1;
    end
    // [R1] hold request pulls the line again
    if (hold_req && st_r.st != HMS_ST_HOLD) begin
      st_nxt.st   = HMS_ST_HOLD;
      st_nxt.pull = 1'b1;
      st_nxt.cnt  = '0;
      st_nxt.pend = 1'b0;
      st_nxt.tmo  = st_nxt.tmo & ~st_r.tmo;
    end
  end

  // [R2] pulled from reset, well inside 50 ms
  // [R19] passthrough select left undriven after reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{st: HMS_ST_HOLD, pull: 1'b1, bypass: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // [R3] only ever pulls low; release is enable off
  assign host_hold_line_n_o  = 1'b0;
  assign host_hold_line_n_oe = st_r.pull;
  assign host_held           = st_r.pull;
  assign host_running        = (st_r.st == HMS_ST_RUN);
  assign host_self_reset     = st_r.self_rst;
  assign release_timeout     = st_r.tmo;
  assign host_power_down     = ~host_present;
  assign host_power_lost     = st_r.pwr_lost;
  assign ee_refused          = st_r.refused;

  // ----------------------------------------
  // Passthrough and UART routing
  // ----------------------------------------
  // [R19] drive high only to leave passthrough
  assign passthrough_select_n_o  = 1'b1;
  assign passthrough_select_n_oe = ~st_r.bypass;
  assign passthrough_active      = st_r.bypass;

  // [R8] direct path in passthrough
  // [R9] crossed onto the host-side UART otherwise
  assign xcvr_txd      = st_r.bypass ? host_txd : net_uart_txd;
  assign host_rxd      = st_r.bypass ? xcvr_rxd : host_uart_txd;
  // Idle-high lines keep the unused UART receivers quiet
  assign host_uart_rxd = st_r.bypass ? 1'b1 : host_txd;
  assign net_uart_rxd  = st_r.bypass ? 1'b1 : xcvr_rxd;
  // [R10] host enable only watched outside passthrough
  assign transceiver_drive_enable = st_r.bypass ? ~half_duplex_tx_enable_n : net_uart_de;
  assign host_tx_enable_monitor   = ~st_r.bypass & ~half_duplex_tx_enable_n;

  // ----------------------------------------
  // Host SPI link and attention line
  // ----------------------------------------
  // [R11] answer only while select is low
  // [R12] select ignored in passthrough
  assign spi_core_select_n       = st_r.bypass | host_link_select_n;
  assign host_miso_o             = spi_core_miso;
  assign host_miso_oe            = ~spi_core_select_n;
  assign host_attention_irq_n_o  = 1'b0;
  assign host_attention_irq_n_oe = attn_req & ~st_r.bypass;

  // ----------------------------------------
  // Shared I2C bus
  // ----------------------------------------
  hms_i2c_master u_i2c_master (
    .clk_sys (clk_sys),
    .srst    (srst),
    .start   (ee_go),
    .cmd     (ee_cmd),
    .scl_i   (i2c_scl_i),
    .sda_i   (i2c_sda_i),
    .busy    (ee_busy),
    .rsp     (ee_rsp),
    .scl_oe  (m_scl_oe),
    .sda_oe  (m_sda_oe)
  );

  // [R18] no drive without host pull-ups
  assign i2c_scl_o  = 1'b0;
  assign i2c_sda_o  = 1'b0;
  assign i2c_scl_oe = m_scl_oe & host_present;
  assign i2c_sda_oe = m_sda_oe & host_present;
  // [R13] slave whenever a host is attached and the master is not running
  assign i2c_slave_en   = host_present & ~ee_busy;
  // [R17] distinct from the EEPROM address
  assign i2c_slave_addr = `HMS_SLV_ADDR;

endmodule : hms_supervisor

//--- hms_supervisor_properties.sv
// Port checks for the supervisor
`timescale 1ns/1ps
module hms_sup_properties #(
  parameter int HOLD_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic host_hold_line_n_i,
  input wire logic host_hold_line_n_o,
  input wire logic host_hold_line_n_oe,
  input wire logic hold_req,
  input wire logic host_held,
  input wire logic host_self_reset,
  input wire logic dock_rail_status,
  input wire logic wire_conn_rail_status,
  input wire logic passthrough_active,
  input wire logic passthrough_select_n_oe,
  input wire logic spi_core_select_n,
  input wire logic host_miso_oe,
  input wire logic i2c_scl_oe,
  input wire logic i2c_sda_oe,
  input wire logic i2c_slave_en,
  input wire logic ee_req,
  input wire logic ee_busy,
  input wire logic ee_refused
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic        host_ok;
  logic [15:0] held_cnt_r;
  assign host_ok = dock_rail_status && wire_conn_rail_status;
  always_ff @(posedge clk_sys) begin
    if (srst || !host_hold_line_n_oe) held_cnt_r <= 16'h0000;
    else held_cnt_r <= held_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_hold_open_drain: assert property (host_hold_line_n_o == 1'b0)
    else $error("hold line driven high");
  chk_held_follows_pull: assert property (host_held == host_hold_line_n_oe)
    else $error("held flag differs from pull");
  chk_hold_req_pulls: assert property (!host_hold_line_n_oe && hold_req |=> host_hold_line_n_oe)
    else $error("hold request not applied");
  chk_min_hold_time: assert property ($fell(host_hold_line_n_oe) |-> held_cnt_r + 16'h0001 >= HOLD_CYC)
    else $error("hold released too early");
  chk_release_not_busy: assert property ($fell(host_hold_line_n_oe) |-> !$past(ee_busy))
    else $error("release during eeprom access");
  chk_master_when_held: assert property (i2c_scl_oe || i2c_sda_oe |-> host_held && host_ok)
    else $error("bus mastered while host free");
  chk_slave_enable: assert property (i2c_slave_en == (host_ok && !ee_busy))
    else $error("slave enable wrong");
  chk_self_reset_cause: assert property (host_self_reset |-> !host_held && !$past(host_hold_line_n_i))
    else $error("self reset without cause");
  chk_passthrough_idle: assert property (passthrough_active |-> !passthrough_select_n_oe && spi_core_select_n
    && !host_miso_oe)
    else $error("passthrough pins active");
  chk_refuse_free_host: assert property (ee_req && !host_held |=> ee_refused)
    else $error("eeprom request not refused");
  cov_ee_done: cover property ($fell(ee_busy));
  cov_self_reset: cover property (host_self_reset);
  cov_refused: cover property (ee_refused);
endmodule : hms_sup_properties

bind hms_supervisor hms_sup_properties #(.HOLD_CYC(HOLD_CYC)) i_hms_sup_properties (.*);

//--- hms_host_model.sv
// Host side model: reset circuit, pull-ups, EEPROM
`timescale 1ns/1ps
module hms_host_model #(
  parameter logic [7:0] RD_BYTE = 8'h5a
) (
  input  wire logic       clk_sys,
  input  wire logic       hold_oe,
  input  wire logic       self_pull,
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  input  wire logic       ack_en,
  input  wire logic [7:0] rel_dly,
  output logic            hold_line,
  output logic            scl,
  output logic            sda,
  output logic [7:0]      first_byte,
  output logic [7:0]      rd_addr
);
  // ----------------------------------------
  // Behaviour
  // ----------------------------------------
  logic [7:0] dly_r    = 8'h00;
  logic       slv_pull = 1'b0;
  logic       rd       = 1'b0;
  logic [7:0] sh       = 8'h00;
  int         bitc     = 0;
  int         bytec    = 0;
  // reset lasts rel_dly cycles after release
  always @(posedge clk_sys) begin
    if (hold_oe) dly_r <= rel_dly;
    else if (dly_r != 8'h00) dly_r <= dly_r - 8'h01;
  end
  assign hold_line = !(hold_oe || self_pull || dly_r != 8'h00);
  assign scl = !scl_oe;
  assign sda = !(sda_oe || slv_pull);
  always @(negedge sda) begin
    if (scl) begin
      bitc  = 0;
      bytec = 0;
    end
  end
  always @(posedge scl) begin
    sh   = {sh[6:0], sda};
    bitc = bitc + 1;
  end
  // ack, log address bytes, drive read byte
  always @(negedge scl) begin
    slv_pull = 1'b0;
    if (bitc == 8) begin
      if (bytec == 0) rd = sh[0];
      if (bytec == 0 && !sh[0]) first_byte = sh;
      if (bytec == 0 && sh[0]) rd_addr = sh;
      slv_pull = ack_en && !(rd && bytec != 0);
      bytec = bytec + 1;
    end
    if (bitc == 9) bitc = 0;
    // First data byte only, never blocks a stop
    if (rd && bytec == 1 && bitc < 8) slv_pull = !RD_BYTE[7 - bitc];
  end
endmodule : hms_host_model

//--- hms_supervisor_bench.sv
// Self-checking bench for the host module supervisor
`timescale 1ns/1ps
module hms_supervisor_bench;
  import hms_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int HOLD_CYC    = 8;
  localparam int RELEASE_CYC = 40;
  logic        clk_sys = 1'b0, srst = 1'b1, hold_req = 1'b0, release_req = 1'b0, auto_release = 1'b0;
  logic        dock_rail_status = 1'b1, wire_conn_rail_status = 1'b1, passthrough_req = 1'b1;
  logic        host_txd = 1'b0, half_duplex_tx_enable_n = 1'b1, host_uart_txd = 1'b0, net_uart_txd = 1'b0;
  logic        net_uart_de = 1'b0, xcvr_rxd = 1'b0, host_link_select_n = 1'b1, spi_core_miso = 1'b0;
  logic        attn_req = 1'b0, ee_req = 1'b0, self_pull = 1'b0, ack_en = 1'b1;
  logic [7:0]  rel_dly = 8'h05;
  hms_ee_cmd_t ee_cmd = '0;
  logic        host_hold_line_n_i, host_hold_line_n_o, host_hold_line_n_oe, host_held, host_running;
  logic        host_self_reset, release_timeout, host_power_down, host_power_lost, passthrough_select_n_o;
  logic        passthrough_select_n_oe, passthrough_active, host_rxd, host_tx_enable_monitor, host_uart_rxd;
  logic        net_uart_rxd, xcvr_txd, transceiver_drive_enable, spi_core_select_n, host_miso_o, host_miso_oe;
  logic        host_attention_irq_n_o, host_attention_irq_n_oe, i2c_scl_i, i2c_sda_i, i2c_scl_o, i2c_scl_oe;
  logic        i2c_sda_o, i2c_sda_oe, i2c_slave_en, ee_busy, ee_refused;
  logic [6:0]  i2c_slave_addr;
  logic [7:0]  first_byte, rd_addr;
  hms_ee_rsp_t ee_rsp;
  int          err_count = 0;
  int          checks = 0;
  int          n;
  hms_supervisor #(.HOLD_CYC(HOLD_CYC), .RELEASE_CYC(RELEASE_CYC)) i_hms_supervisor (.*);
  hms_host_model i_hms_host_model (.clk_sys(clk_sys), .hold_oe(host_hold_line_n_oe), .self_pull(self_pull),
    .scl_oe(i2c_scl_oe), .sda_oe(i2c_sda_oe), .ack_en(ack_en), .rel_dly(rel_dly),
    .hold_line(host_hold_line_n_i), .scl(i2c_scl_i), .sda(i2c_sda_i), .first_byte(first_byte),
    .rd_addr(rd_addr));
  initial forever #25 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  function automatic logic sig_of(input int w);
    case (w)
      0: return ee_rsp.done;
      1: return host_running;
      2: return host_self_reset;
      default: return release_timeout;
    endcase
  endfunction : sig_of
  // Bounded wait
  task automatic wait_for(input int w, input int lim);
    int k;
    for (k = 0; sig_of(w) !== 1'b1 && k < lim; k++) tick(1);
    cmp_bit(sig_of(w), 1'b1);
  endtask : wait_for
  task automatic ee_op(input logic rd, input logic [7:0] addr, input logic refuse);
    @(posedge clk_sys);
    ee_req <= 1'b1;
    ee_cmd <= '{rd: rd, addr: addr, wdata: ~addr};
    @(posedge clk_sys);
    ee_req <= 1'b0;
    #1;
    cmp_bit(ee_refused, refuse);
    if (!refuse) wait_for(0, 20000);
  endtask : ee_op
  // Both patterns on every routed input
  task automatic route_check(input logic pass);
    logic [5:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 6'h15 : 6'h2a;
      @(posedge clk_sys);
      {host_txd, xcvr_rxd, host_uart_txd, net_uart_txd, net_uart_de, half_duplex_tx_enable_n} <= v;
      #1;
      if (pass) begin
        cmp_bit(xcvr_txd, v[5]);
        cmp_bit(host_rxd, v[4]);
        cmp_bit(transceiver_drive_enable, ~v[0]);
      end else begin
        cmp_bit(host_uart_rxd, v[5]);
        cmp_bit(net_uart_rxd, v[4]);
        cmp_bit(host_rxd, v[3]);
        cmp_bit(xcvr_txd, v[2]);
        cmp_bit(transceiver_drive_enable, v[1]);
        cmp_bit(host_tx_enable_monitor, ~v[0]);
      end
    end
  endtask : route_check
  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #5000000;
    err_count++;
    report_and_stop();
  end
  initial begin
    tick(12);
    srst <= 1'b0;
    cmp_bit(host_held, 1'b1);
    cmp_bit(passthrough_active, 1'b1);
    route_check(1'b1);
    host_link_select_n <= 1'b0;
    attn_req <= 1'b1;
    tick(1);
    cmp_bit(spi_core_select_n, 1'b1);
    cmp_bit(host_attention_irq_n_oe, 1'b0);
    ee_op(1'b0, 8'h10, 1'b0);
    cmp_byte(first_byte, 8'ha2);
    ee_op(1'b1, 8'hff, 1'b0);
    cmp_byte(rd_addr, 8'ha3);
    cmp_byte(ee_rsp.rdata, 8'h5a);
    cmp_bit(ee_rsp.nack, 1'b0);
    ack_en <= 1'b0;
    ee_op(1'b0, 8'h00, 1'b0);
    cmp_bit(ee_rsp.nack, 1'b1);
    cmp_bit(i2c_sda_i & i2c_scl_i, 1'b1);
    ack_en <= 1'b1;
    for (int r = 1; r < 3; r++) begin
      {dock_rail_status, wire_conn_rail_status} <= r[1:0];
      tick(1);
      cmp_bit(host_power_down, 1'b1);
      ee_op(1'b1, 8'h01, 1'b1);
    end
    {dock_rail_status, wire_conn_rail_status} <= 2'b11;
    passthrough_req <= 1'b0;
    tick(2);
    cmp_bit(host_power_down, 1'b0);
    cmp_bit(passthrough_select_n_oe, 1'b1);
    route_check(1'b0);
    spi_core_miso <= 1'b1;
    tick(1);
    cmp_bit(spi_core_select_n, 1'b0);
    cmp_bit(host_miso_oe & host_miso_o, 1'b1);
    host_link_select_n <= 1'b1;
    tick(1);
    cmp_bit(host_miso_oe, 1'b0);
    release_req <= 1'b1;
    tick(1);
    release_req <= 1'b0;
    wait_for(1, 300);
    cmp_bit(host_held, 1'b0);
    cmp_bit(i2c_slave_en, 1'b1);
    ee_op(1'b0, 8'h20, 1'b1);
    self_pull <= 1'b1;
    wait_for(2, 10);
    cmp_bit(host_held, 1'b0);
    self_pull <= 1'b0;
    tick(3);
    auto_release <= 1'b1;
    rel_dly <= 8'h64;
    hold_req <= 1'b1;
    tick(1);
    hold_req <= 1'b0;
    cmp_bit(host_hold_line_n_i, 1'b0);
    n = 0;
    while (host_held === 1'b1 && n < 50) begin
      cmp_bit(host_hold_line_n_o, 1'b0);
      tick(1);
      n++;
    end
    cmp_bit(n >= HOLD_CYC, 1'b1);
    wait_for(3, 100);
    cmp_bit(host_running, 1'b0);
    hold_req <= 1'b1;
    tick(1);
    hold_req <= 1'b0;
    tick(2);
    cmp_bit(release_timeout, 1'b0);
    report_and_stop();
  end
endmodule : hms_supervisor_bench
